// file: design/ccr_config_regs.v
// Configuration register bank of the clock synthesiser
`timescale 1ns/1ps
`include "ccr_regs.vh"
module ccr_config_regs (
  input  wire        clk,             // 50 MHz system clock
  input  wire        resetn,          // Asynchronous reset, active low
  input  wire [7:0]  addr,            // Register byte address
  input  wire [7:0]  wdata,           // Write data
  input  wire        wr,              // Write strobe
  input  wire        rd,              // Read strobe
  output reg  [7:0]  rdata,           // Read data, cycle after rd
  input  wire [7:0]  store_start_flags, // Startup flags from nonvolatile_store
  input  wire        store_valid,       // Store contents available
  input  wire        bank_b_active,   // Bank b selected as the active bank
  output reg  [1:0]  dev_state,       // Startup, ready or active
  output reg         bank_b_spread_enable,          // Spread on
  output reg  [1:0]  bank_b_spread_mode,            // Spread mode
  output reg  [11:0] bank_b_spread_step_count,      // Steps per quarter
  output reg  [11:0] bank_b_spread_step_integer,    // Step size
  output reg  [14:0] bank_b_spread_step_remainder,  // Step error numerator
  output reg  [14:0] pll_feedback_integer,          // Feedback integer term
  output reg  [14:0] pll_feedback_remainder,        // Feedback remainder
  output reg  [14:0] pll_feedback_denominator,      // Feedback denominator
  output reg  [4:0]  pll_prescaler_ratio,           // Prescaler ratio
  output reg  [3:0]  first_output_driver_config,    // Output 0 driver code
  output reg  [7:0]  startup_behaviour_flags,       // Startup flags
  output reg  [3:0]  pll_bandwidth_select,          // PLL bandwidth
  output reg         crystal_extra_load_enable,     // Extra 8 pF load
  output reg  [5:0]  crystal_trim_pin_a,            // Trim on crystal_pin_a
  output reg  [5:0]  crystal_trim_pin_b             // Trim on crystal_pin_b
);

  // ============================================================
  // Write qualification
  wire        is_ready    = (dev_state == `CCR_ST_READY);   // Ready state
  wire        ready_wr    = wr & is_ready;                   // Ready-only fields
  // Bank fields except enable are frozen while bank b is the active bank and the device is in the active state
  wire        bank_wr     = wr & ~(bank_b_active & (dev_state == `CCR_ST_ACTIVE));

  // Address match helper, used for the state machine and spread bank decodes
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // ============================================================
  // Device state machine with startup flag capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_state               <= `CCR_ST_STARTUP;
      startup_behaviour_flags <= `CCR_RST_BYTE;
    end else begin
      case (dev_state)
        `CCR_ST_STARTUP: begin
          // Wait for the store; flags are looked at only here
          if (store_valid) begin
            startup_behaviour_flags <= store_start_flags;
            if (store_start_flags[`CCR_F_AUTO_ACTIVE])
              dev_state <= `CCR_ST_ACTIVE;
            else
              dev_state <= `CCR_ST_READY;
          end
        end
        `CCR_ST_READY: begin
          if (ready_wr && hit(addr, `CCR_A_START_FLAGS))
            startup_behaviour_flags <= wdata;
          if (wr && hit(addr, `CCR_A_COMMAND) && wdata == `CCR_CMD_GO_ACTIVE)
            dev_state <= `CCR_ST_ACTIVE;
        end
        `CCR_ST_ACTIVE: begin
          if (wr && hit(addr, `CCR_A_COMMAND) && wdata == `CCR_CMD_GO_READY)
            dev_state <= `CCR_ST_READY;
        end
        default: dev_state <= `CCR_ST_STARTUP;
      endcase
    end
  end

  // ============================================================
  // Spread spectrum bank b
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_b_spread_enable         <= 1'b0;
      bank_b_spread_mode           <= `CCR_SS_MODE_OFF;
      bank_b_spread_step_count     <= `CCR_RST_12;
      bank_b_spread_step_integer   <= `CCR_RST_12;
      bank_b_spread_step_remainder <= `CCR_RST_15;
    end else begin
      // Enable may change at any time, even on the live bank
      if (wr && hit(addr, `CCR_A_SS_CTRL)) begin
        bank_b_spread_enable <= wdata[`CCR_F_SS_EN];
      end
      // Mode write ignored if invalid value two is presented
      if (bank_wr && hit(addr, `CCR_A_SS_CTRL) &&
          wdata[`CCR_F_SS_MODE_LO+1 -: 2] != `CCR_SS_MODE_BAD) begin
        bank_b_spread_mode <= wdata[`CCR_F_SS_MODE_LO+1 -: 2];
      end
      if (bank_wr && hit(addr, `CCR_A_SS_CNT_LO))
        bank_b_spread_step_count[7:0] <= wdata;
      if (bank_wr && hit(addr, `CCR_A_SS_CNT_HI))
        bank_b_spread_step_count[11:8] <= wdata[3:0];
      if (bank_wr && hit(addr, `CCR_A_SS_INT_LO))
        bank_b_spread_step_integer[7:0] <= wdata;
      if (bank_wr && hit(addr, `CCR_A_SS_INT_HI))
        bank_b_spread_step_integer[11:8] <= wdata[3:0];
      if (bank_wr && hit(addr, `CCR_A_SS_RES_LO))
        bank_b_spread_step_remainder[7:0] <= wdata;
      if (bank_wr && hit(addr, `CCR_A_SS_RES_HI))
        bank_b_spread_step_remainder[14:8] <= wdata[6:0];
    end
  end

  // ============================================================
  // PLL settings, output driver and crystal, all ready-only
  // Feedback terms are stored as given; the a+b/c encoding is software's job
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_feedback_integer       <= `CCR_RST_15;
      pll_feedback_remainder     <= `CCR_RST_15;
      pll_feedback_denominator   <= `CCR_RST_15;
      pll_prescaler_ratio        <= `CCR_RST_5;
      first_output_driver_config <= `CCR_RST_4;
      pll_bandwidth_select       <= `CCR_RST_4;
      crystal_extra_load_enable  <= 1'b0;
      crystal_trim_pin_a         <= `CCR_RST_6;
      crystal_trim_pin_b         <= `CCR_RST_6;
    end else if (ready_wr) begin
      case (addr)
        `CCR_A_FB_INT_LO: pll_feedback_integer[7:0]      <= wdata;
        `CCR_A_FB_INT_HI: pll_feedback_integer[14:8]     <= wdata[6:0];
        `CCR_A_FB_RES_LO: pll_feedback_remainder[7:0]    <= wdata;
        `CCR_A_FB_RES_HI: pll_feedback_remainder[14:8]   <= wdata[6:0];
        `CCR_A_FB_DEN_LO: pll_feedback_denominator[7:0]  <= wdata;
        `CCR_A_FB_DEN_HI: pll_feedback_denominator[14:8] <= wdata[6:0];
        `CCR_A_PRESCALE:  pll_prescaler_ratio            <= wdata[4:0];
        `CCR_A_OUT0_CFG:  first_output_driver_config     <= wdata[3:0];
        `CCR_A_PLL_BW:    pll_bandwidth_select <= wdata[`CCR_F_PLL_BW_LO+3 -: 4];
        `CCR_A_XO_LOAD:   crystal_extra_load_enable <= wdata[`CCR_F_XO_EXTRA];
        `CCR_A_XO_TRIM_A: crystal_trim_pin_a             <= wdata[5:0];
        `CCR_A_XO_TRIM_B: crystal_trim_pin_b             <= wdata[5:0];
        default: ;
      endcase
    end
  end

  // ============================================================
  // Read mux, registered one cycle after the strobe
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `CCR_RST_BYTE;
    case (addr)
      `CCR_A_SS_CTRL:     next_rdata = {5'h00, bank_b_spread_mode, bank_b_spread_enable};
      `CCR_A_SS_CNT_LO:   next_rdata = bank_b_spread_step_count[7:0];
      `CCR_A_SS_CNT_HI:   next_rdata = {4'h0, bank_b_spread_step_count[11:8]};
      `CCR_A_SS_INT_LO:   next_rdata = bank_b_spread_step_integer[7:0];
      `CCR_A_SS_INT_HI:   next_rdata = {4'h0, bank_b_spread_step_integer[11:8]};
      `CCR_A_SS_RES_LO:   next_rdata = bank_b_spread_step_remainder[7:0];
      `CCR_A_SS_RES_HI:   next_rdata = {1'b0, bank_b_spread_step_remainder[14:8]};
      `CCR_A_FB_INT_LO:   next_rdata = pll_feedback_integer[7:0];
      `CCR_A_FB_INT_HI:   next_rdata = {1'b0, pll_feedback_integer[14:8]};
      `CCR_A_FB_RES_LO:   next_rdata = pll_feedback_remainder[7:0];
      `CCR_A_FB_RES_HI:   next_rdata = {1'b0, pll_feedback_remainder[14:8]};
      `CCR_A_FB_DEN_LO:   next_rdata = pll_feedback_denominator[7:0];
      `CCR_A_FB_DEN_HI:   next_rdata = {1'b0, pll_feedback_denominator[14:8]};
      `CCR_A_PRESCALE:    next_rdata = {3'h0, pll_prescaler_ratio};
      `CCR_A_OUT0_CFG:    next_rdata = {4'h0, first_output_driver_config};
      `CCR_A_START_FLAGS: next_rdata = startup_behaviour_flags;
      `CCR_A_PLL_BW:      next_rdata = {2'h0, pll_bandwidth_select, 2'h0};
      `CCR_A_XO_LOAD:     next_rdata = {crystal_extra_load_enable, 7'h00};
      `CCR_A_XO_TRIM_A:   next_rdata = {2'h0, crystal_trim_pin_a};
      `CCR_A_XO_TRIM_B:   next_rdata = {2'h0, crystal_trim_pin_b};
      `CCR_A_DEV_STATE:   next_rdata = {6'h00, dev_state};
      default:            next_rdata = `CCR_RST_BYTE;  // Unmapped reads zero
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      rdata <= `CCR_RST_BYTE;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= `CCR_RST_BYTE;
  end

endmodule // ccr_config_regs

// file: design/ccr_regs.vh
// Register map, field layout and state codes of the clock synth config bank
`ifndef CCR_REGS_VH
`define CCR_REGS_VH
// ============================================================
// Byte addresses (8-bit registers, multi-byte fields little endian)
`define CCR_A_SS_CTRL     8'h60
`define CCR_A_SS_CNT_LO   8'h61
`define CCR_A_SS_CNT_HI   8'h62
`define CCR_A_SS_INT_LO   8'h63
`define CCR_A_SS_INT_HI   8'h64
`define CCR_A_SS_RES_LO   8'h65
`define CCR_A_SS_RES_HI   8'h66
`define CCR_A_FB_INT_LO   8'h67
`define CCR_A_FB_INT_HI   8'h68
`define CCR_A_FB_RES_LO   8'h69
`define CCR_A_FB_RES_HI   8'h6a
`define CCR_A_FB_DEN_LO   8'h6b
`define CCR_A_FB_DEN_HI   8'h6c
`define CCR_A_PRESCALE    8'h75
`define CCR_A_OUT0_CFG    8'h7a
`define CCR_A_START_FLAGS 8'hb8
`define CCR_A_PLL_BW      8'hbe
`define CCR_A_XO_LOAD     8'hbf
`define CCR_A_XO_TRIM_A   8'hc0
`define CCR_A_XO_TRIM_B   8'hc1
`define CCR_A_DEV_STATE   8'hf0
`define CCR_A_COMMAND     8'hf1
// ============================================================
// Field positions
`define CCR_F_SS_EN       0
`define CCR_F_SS_MODE_LO  1
`define CCR_F_PLL_BW_LO   2
`define CCR_F_XO_EXTRA    7
`define CCR_F_AUTO_ACTIVE 0
// ============================================================
// Spread modes
`define CCR_SS_MODE_OFF    2'h0
`define CCR_SS_MODE_CENTRE 2'h1
`define CCR_SS_MODE_BAD    2'h2
`define CCR_SS_MODE_DOWN   2'h3
// ============================================================
// Device states and commands
`define CCR_ST_STARTUP 2'h0
`define CCR_ST_READY   2'h1
`define CCR_ST_ACTIVE  2'h2
`define CCR_CMD_GO_ACTIVE 8'h01
`define CCR_CMD_GO_READY  8'h02
// ============================================================
// Reset values
`define CCR_RST_BYTE   8'h00
`define CCR_RST_12     12'h000
`define CCR_RST_15     15'h0000
`define CCR_RST_5      5'h00
`define CCR_RST_4      4'h0
`define CCR_RST_6      6'h00
`define CCR_RST_2      2'h0
`endif

// file: tb/ccr_config_regs_assertions.sv
// Port checker of the clock synth config bank, bound to the design
`timescale 1ns/1ps
`include "ccr_regs.vh"
// ============================================================
// Checker module
module ccr_checker (
  input wire       clk,                        // System clock
  input wire       resetn,                     // Async reset, active low
  input wire [7:0] addr,                       // Byte address
  input wire [7:0] wdata,                      // Write data
  input wire       wr,                         // Write strobe
  input wire       rd,                         // Read strobe
  input wire [7:0] rdata,                      // Read data
  input wire [7:0] store_start_flags,          // Flags from store
  input wire       store_valid,                // Store ready
  input wire       bank_b_active,              // Bank b active
  input wire [1:0] dev_state,                  // Device state
  input wire       bank_b_spread_enable,       // Spread on
  input wire [1:0] bank_b_spread_mode,         // Spread mode
  input wire [4:0] pll_prescaler_ratio,        // Prescaler ratio
  input wire [3:0] first_output_driver_config, // Driver code
  input wire [7:0] startup_behaviour_flags,    // Startup flags
  input wire       crystal_extra_load_enable,  // Extra load
  input wire [5:0] crystal_trim_pin_a          // Pin a trim
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rdy = dev_state == `CCR_ST_READY;                 // Ready state
  wire w60 = wr && addr == `CCR_A_SS_CTRL;               // Spread control write
  wire w75 = wr && addr == `CCR_A_PRESCALE;              // Prescaler write
  wire live = bank_b_active && dev_state == `CCR_ST_ACTIVE; // Bank locked
  a_prescale_write: assert property (w75 && rdy |=> pll_prescaler_ratio == $past(wdata[4:0]))
    else $error("prescaler not written in ready");
  a_prescale_locked: assert property (w75 && !rdy |=> $stable(pll_prescaler_ratio))
    else $error("prescaler changed outside ready");
  a_driver_locked: assert property (wr && addr == `CCR_A_OUT0_CFG && !rdy
    |=> $stable(first_output_driver_config)) else $error("driver code changed outside ready");
  a_spread_enable_any: assert property (w60 |=> bank_b_spread_enable == $past(wdata[0]))
    else $error("spread enable not written");
  a_spread_mode_held: assert property (w60 && live |=> $stable(bank_b_spread_mode))
    else $error("spread mode changed on live bank");
  a_mode_never_bad: assert property (bank_b_spread_mode != `CCR_SS_MODE_BAD)
    else $error("spread mode holds invalid code");
  a_extra_load_bit: assert property (wr && addr == `CCR_A_XO_LOAD && rdy
    |=> crystal_extra_load_enable == $past(wdata[7])) else $error("extra load bit wrong");
  a_trim_a_write: assert property (wr && addr == `CCR_A_XO_TRIM_A && rdy
    |=> crystal_trim_pin_a == $past(wdata[5:0])) else $error("trim a not written");
  a_flags_capture: assert property (dev_state == `CCR_ST_STARTUP && store_valid |=>
    startup_behaviour_flags == $past(store_start_flags) && dev_state ==
    ($past(store_start_flags[0]) ? `CCR_ST_ACTIVE : `CCR_ST_READY)) else $error("bad startup");
  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00) else $error("read data not zero");
  c_prescale: cover property (w75 && rdy);
  c_live_write: cover property (w60 && live);
  c_auto_active: cover property (dev_state == `CCR_ST_STARTUP ##1 dev_state == `CCR_ST_ACTIVE);
endmodule // ccr_checker

bind ccr_config_regs ccr_checker ccr_checker_i (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .store_start_flags(store_start_flags),
  .store_valid(store_valid), .bank_b_active(bank_b_active), .dev_state(dev_state),
  .bank_b_spread_enable(bank_b_spread_enable), .bank_b_spread_mode(bank_b_spread_mode),
  .pll_prescaler_ratio(pll_prescaler_ratio), .startup_behaviour_flags(startup_behaviour_flags),
  .first_output_driver_config(first_output_driver_config), .crystal_trim_pin_a(crystal_trim_pin_a),
  .crystal_extra_load_enable(crystal_extra_load_enable));

// file: tb/testbench.sv
// Self-checking bench of the clock synth config bank
`timescale 1ns/1ps
`include "ccr_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  // ============================================================
  // Stimulus and design
  logic        clk = 0;                         // 50 MHz clock
  logic        resetn = 0;                      // Reset, active low
  logic [7:0]  addr = 0, wdata = 0, flg = 0;    // Bus and store flags
  logic        wr = 0, rd = 0, nv = 0, act = 0; // Strobes and levels
  wire  [7:0]  rdata, sf;                       // Read data, startup flags
  wire  [1:0]  st, md;                          // State, spread mode
  wire  [11:0] cnt, sint;                       // Spread step fields
  wire  [14:0] sres, fbi, fbr, fbd;             // Remainder and feedback terms
  wire  [5:0]  ta, tb;                          // Crystal trims
  wire  [4:0]  pre;                             // Prescaler
  wire  [3:0]  drv, bw;                         // Driver code, bandwidth
  wire         en, xl;                          // Spread enable, extra load
  int          error_cnt = 0, n_tests = 0;      // Verdict counters
  always #10 clk = ~clk;
  ccr_config_regs ccr_config_regs_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .store_start_flags(flg), .store_valid(nv),
    .bank_b_active(act),
    .dev_state(st), .bank_b_spread_enable(en), .bank_b_spread_mode(md),
    .bank_b_spread_step_count(cnt), .bank_b_spread_step_integer(sint),
    .bank_b_spread_step_remainder(sres), .pll_feedback_integer(fbi),
    .pll_feedback_remainder(fbr), .pll_feedback_denominator(fbd), .pll_prescaler_ratio(pre),
    .first_output_driver_config(drv), .startup_behaviour_flags(sf), .pll_bandwidth_select(bw),
    .crystal_extra_load_enable(xl), .crystal_trim_pin_a(ta), .crystal_trim_pin_b(tb));
  // ============================================================
  // Bus tasks; each ends mid-cycle so register updates have landed
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 0;
    @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); rd <= 1; addr <= a;
    @(posedge clk); rd <= 0;
    @(negedge clk); `CHK("rdata", e, rdata)
  endtask
  // Bounded wait for the store load to move the state on
  task automatic wait_start();
    for (int i = 0; i < 10 && st === `CCR_ST_STARTUP; i++) @(negedge clk);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_startup();
    `CHK("reset", 1'b0, |{pre, drv, sf, bw, xl, ta, tb, en, md, cnt, fbi})
    wreg(`CCR_A_PRESCALE, 8'h07);
    `CHK("pre", 5'h00, pre)
    @(posedge clk); flg <= 8'h5a; nv <= 1; wait_start();
    `CHK("state", `CCR_ST_READY, st)
    `CHK("flags", 8'h5a, sf)
  endtask
  task automatic t_ready();
    wreg(`CCR_A_PRESCALE, 8'hff); `CHK("pre", 5'h1f, pre)
    wreg(`CCR_A_OUT0_CFG, 8'h0c); `CHK("drv", 4'hc, drv)
    wreg(`CCR_A_XO_LOAD, 8'h80); `CHK("xl", 1'b1, xl)
    wreg(`CCR_A_XO_TRIM_A, 8'h3f); `CHK("ta", 6'h3f, ta)
    wreg(`CCR_A_XO_TRIM_B, 8'h15); `CHK("tb", 6'h15, tb)
    // Divider 100 + 1/3 encoded by software into three terms
    wreg(`CCR_A_FB_INT_LO, 8'h2a); wreg(`CCR_A_FB_INT_HI, 8'h30);
    wreg(`CCR_A_FB_RES_LO, 8'h02); wreg(`CCR_A_FB_DEN_LO, 8'h03);
    `CHK("fb", {15'h302a, 15'h0002, 15'h0003}, {fbi, fbr, fbd})
    rreg(`CCR_A_PRESCALE, 8'h1f);
    rreg(8'h70, 8'h00);
    wreg(`CCR_A_PLL_BW, 8'h3c); `CHK("bw", 4'hf, bw)
    wreg(`CCR_A_START_FLAGS, 8'ha5); `CHK("flags", 8'ha5, sf)
    rreg(`CCR_A_DEV_STATE, 8'h01);
  endtask
  task automatic t_spread();
    logic [1:0] exp_md;
    exp_md = `CCR_SS_MODE_OFF;
    wreg(`CCR_A_SS_CNT_LO, 8'hbc); wreg(`CCR_A_SS_CNT_HI, 8'h0a);
    `CHK("cnt", 12'habc, cnt)
    wreg(`CCR_A_SS_INT_LO, 8'h23); wreg(`CCR_A_SS_INT_HI, 8'h01);
    `CHK("sint", 12'h123, sint)
    wreg(`CCR_A_SS_RES_LO, 8'hff); wreg(`CCR_A_SS_RES_HI, 8'h7f);
    `CHK("sres", 15'h7fff, sres)
    for (int m = 0; m < 4; m++) begin
      wreg(`CCR_A_SS_CTRL, {5'h00, m[1:0], m[0]});
      if (m != 2) exp_md = m[1:0];
      `CHK("md", exp_md, md)
      `CHK("en", m[0], en)
    end
  endtask
  task automatic t_active();
    wreg(`CCR_A_COMMAND, `CCR_CMD_GO_ACTIVE); @(posedge clk); act <= 1;
    `CHK("state", `CCR_ST_ACTIVE, st)
    wreg(`CCR_A_PRESCALE, 8'h01); `CHK("pre", 5'h1f, pre)
    wreg(`CCR_A_OUT0_CFG, 8'h03); `CHK("drv", 4'hc, drv)
    wreg(`CCR_A_SS_CTRL, 8'h02); `CHK("live", 3'b110, {md, en})
    wreg(`CCR_A_SS_CNT_LO, 8'h00); `CHK("cnt", 12'habc, cnt)
    wreg(`CCR_A_COMMAND, `CCR_CMD_GO_READY); `CHK("state", `CCR_ST_READY, st)
    @(posedge clk); act <= 0;
  endtask
  task automatic t_auto();
    @(posedge clk); resetn <= 0; flg <= 8'h01;
    repeat (2) @(posedge clk);
    resetn <= 1; wait_start();
    `CHK("state", `CCR_ST_ACTIVE, st)
    `CHK("flags", 8'h01, sf)
  endtask
  // ============================================================
  // Verdict and run control
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(negedge clk);
    t_startup(); t_ready(); t_spread(); t_active(); t_auto();
    complete_run();
  end
  // Whole run is under a hundred cycles; this limit is generous
  initial begin
    #100000; error_cnt++; complete_run();
  end
endmodule // testbench
